// *** hdl/cas_pkg.sv ***
package cas_pkg;

    localparam int unsigned CAS_DATA_W = 8;
    localparam int unsigned CAS_PTR_W = 16;
    localparam int unsigned CAS_FADDR_W = 7;
    localparam int unsigned CAS_LIT_W = 6;
    localparam int unsigned CAS_BIT_IDX_W = 3;
    localparam int unsigned CAS_PTR_CNT = 2;
    localparam int unsigned CAS_NIB_MSB = 3;

    localparam logic [7:0] CAS_ACC_RST = 8'h00;
    localparam logic [15:0] CAS_PTR_RST = 16'h0000;
    localparam logic [7:0] CAS_ZERO_BYTE = 8'h00;

    typedef enum logic [3:0] {
        CAS_OP_NONE,
        CAS_OP_ADD_LITERAL_TO_POINTER,
        CAS_OP_AND_LITERAL_INTO_ACC,
        CAS_OP_ADD_LITERAL_INTO_ACC,
        CAS_OP_AND_ACC_WITH_FILE,
        CAS_OP_ADD_ACC_TO_FILE,
        CAS_OP_SHIFT_RIGHT_ARITH,
        CAS_OP_ADD_ACC_FILE_WITH_OVERFLOW,
        CAS_OP_BIT_CLEAR_FILE
    } cas_op_t;

    typedef struct packed {
        cas_op_t op;
        logic [7:0] literal;
        logic [6:0] faddr;
        logic dest_file;
        logic [2:0] bit_idx;
        logic ptr_sel;
    } cas_instr_t;

    typedef struct packed {
        logic carry;
        logic nibble_overflow_flag;
        logic zero;
    } cas_flags_t;

    typedef struct packed {
        logic en;
        logic [6:0] addr;
        logic [7:0] data;
    } cas_fwrite_t;

endpackage : cas_pkg

// *** hdl/cas_datapath.sv ***
`timescale 1ns/1ns
`default_nettype none
module cas_datapath
    import cas_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic instr_valid_in,
    input var cas_instr_t instr_in,
    input wire logic indirect_in,
    input wire logic [7:0] file_rdata_in,
    output logic busy_out,
    output logic done_out,
    output var cas_fwrite_t fwrite_out,
    output logic [7:0] acc_out,
    output var cas_flags_t flags_out,
    output logic [15:0] ptr0_out,
    output logic [15:0] ptr1_out
);

    typedef enum logic {
        CAS_ST_IDLE,
        CAS_ST_STALL
    } cas_state_t;

    cas_state_t state_r, state_nxt;
    cas_instr_t held_r, held_nxt;
    logic [7:0] acc_r, acc_nxt;
    cas_flags_t flags_r, flags_nxt;
    logic [15:0] ptr_r [CAS_PTR_CNT];
    logic [15:0] ptr_nxt [CAS_PTR_CNT];
    cas_fwrite_t fw_r, fw_nxt;
    logic done_r, done_nxt;

    cas_instr_t cur;
    logic exec;
    logic [8:0] sum9;
    logic [4:0] sum5;
    logic [7:0] opb;
    logic cin;
    logic [7:0] res;
    logic [15:0] lit_ext;
    logic stall_ptr_msb;
    localparam int unsigned CAS_SIGN_BIT = CAS_DATA_W - 1;

    // Port widths are fixed by the instruction format; the package must agree
    if ($bits(file_rdata_in) != CAS_DATA_W ||
        $bits(acc_out) != CAS_DATA_W) begin : g_bad_data_w
        $error("data ports differ from the data width");
    end
    if ($bits(ptr0_out) != CAS_PTR_W ||
        $bits(ptr1_out) != CAS_PTR_W) begin : g_bad_ptr_w
        $error("pointer ports differ from the pointer width");
    end
    if ($bits(instr_in.faddr) != CAS_FADDR_W) begin : g_bad_faddr_w
        $error("file address field differs from the address width");
    end
    if ($bits(instr_in.bit_idx) != CAS_BIT_IDX_W || (1 << CAS_BIT_IDX_W) != CAS_DATA_W) begin : g_bad_bit_idx_w
        $error("bit index cannot reach every bit of a byte");
    end
    // Sign extension needs at least one pad bit above the literal
    if (CAS_LIT_W >= CAS_PTR_W || CAS_LIT_W > $bits(instr_in.literal)) begin : g_bad_lit_w
        $error("pointer literal does not fit the literal field or the pointer");
    end
    // One select bit and two pointer ports serve exactly two pairs
    if ((1 << $bits(instr_in.ptr_sel)) != CAS_PTR_CNT) begin : g_bad_ptr_cnt
        $error("pointer count does not match the pointer select");
    end
    if (CAS_NIB_MSB >= CAS_DATA_W - 1) begin : g_bad_nib_msb
        $error("nibble carry point must lie below the top bit");
    end

    // Extra cycle only when the indirect access points into the upper half
    always_comb begin
        stall_ptr_msb = indirect_in && ptr_r[instr_in.ptr_sel][CAS_PTR_W-1];
    end

    always_comb begin
        state_nxt = state_r;
        held_nxt = held_r;
        exec = 1'b0;
        cur = held_r;
        unique case (state_r)
            CAS_ST_IDLE: begin
                if (instr_valid_in) begin
                    if (stall_ptr_msb) begin
                        state_nxt = CAS_ST_STALL;
                        held_nxt = instr_in;
                    end else begin
                        exec = 1'b1;
                        cur = instr_in;
                    end
                end
            end
            CAS_ST_STALL: begin
                // File data is read now, so the memory side must still hold it
                exec = 1'b1;
                state_nxt = CAS_ST_IDLE;
            end
        endcase
    end

    always_comb begin
        acc_nxt = acc_r;
        flags_nxt = flags_r;
        ptr_nxt = ptr_r;
        fw_nxt = '{en: 1'b0, addr: cur.faddr, data: fw_r.data};
        done_nxt = exec;
        opb = file_rdata_in;
        cin = 1'b0;
        res = CAS_ZERO_BYTE;
        lit_ext = {{(CAS_PTR_W-CAS_LIT_W){cur.literal[CAS_LIT_W-1]}}, cur.literal[CAS_LIT_W-1:0]};
        if (cur.op == CAS_OP_ADD_LITERAL_INTO_ACC) begin
            opb = cur.literal;
        end
        if (cur.op == CAS_OP_ADD_ACC_FILE_WITH_OVERFLOW) begin
            cin = flags_r.carry;
        end
        sum9 = {1'b0, acc_r} + {1'b0, opb} + {8'h00, cin};
        sum5 = {1'b0, acc_r[CAS_NIB_MSB:0]} + {1'b0, opb[CAS_NIB_MSB:0]} + {4'h0, cin};
        if (exec) begin
            unique case (cur.op)
                CAS_OP_ADD_LITERAL_TO_POINTER: begin
                    // 16-bit target drops the carry, giving natural wrap
                    ptr_nxt[cur.ptr_sel] = ptr_r[cur.ptr_sel] + lit_ext;
                end
                CAS_OP_AND_LITERAL_INTO_ACC: begin
                    res = acc_r & cur.literal;
                    acc_nxt = res;
                    flags_nxt.zero = (res == CAS_ZERO_BYTE);
                end
                CAS_OP_ADD_LITERAL_INTO_ACC: begin
                    res = sum9[7:0];
                    acc_nxt = res;
                end
                CAS_OP_AND_ACC_WITH_FILE: begin
                    res = acc_r & file_rdata_in;
                    flags_nxt.zero = (res == CAS_ZERO_BYTE);
                end
                CAS_OP_ADD_ACC_TO_FILE, CAS_OP_ADD_ACC_FILE_WITH_OVERFLOW: begin
                    res = sum9[7:0];
                end
                CAS_OP_SHIFT_RIGHT_ARITH: begin
                    // Sign copy keeps negative values negative
                    res = {file_rdata_in[CAS_SIGN_BIT], file_rdata_in[CAS_SIGN_BIT:1]};
                    flags_nxt.carry = file_rdata_in[0];
                    flags_nxt.zero = (res == CAS_ZERO_BYTE);
                end
                CAS_OP_BIT_CLEAR_FILE: begin
                    res = file_rdata_in;
                    res[cur.bit_idx] = 1'b0;
                    fw_nxt.en = 1'b1;
                    fw_nxt.data = res;
                end
                default: begin
                end
            endcase
            // The three byte adds share the flag update; the pointer add leaves the flags alone
            if (cur.op inside {CAS_OP_ADD_LITERAL_INTO_ACC, CAS_OP_ADD_ACC_TO_FILE,
                               CAS_OP_ADD_ACC_FILE_WITH_OVERFLOW}) begin
                flags_nxt.carry = sum9[8];
                flags_nxt.nibble_overflow_flag = sum5[4];
                flags_nxt.zero = (res == CAS_ZERO_BYTE);
            end
            if (cur.op inside {CAS_OP_AND_ACC_WITH_FILE, CAS_OP_ADD_ACC_TO_FILE,
                               CAS_OP_ADD_ACC_FILE_WITH_OVERFLOW, CAS_OP_SHIFT_RIGHT_ARITH}) begin
                if (cur.dest_file) begin
                    fw_nxt.en = 1'b1;
                    fw_nxt.data = res;
                end else begin
                    acc_nxt = res;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_r <= CAS_ST_IDLE;
            held_r <= '0;
            acc_r <= CAS_ACC_RST;
            flags_r <= '0;
            for (int i = 0; i < CAS_PTR_CNT; i++) begin
                ptr_r[i] <= CAS_PTR_RST;
            end
            fw_r <= '0;
            done_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            held_r <= held_nxt;
            acc_r <= acc_nxt;
            flags_r <= flags_nxt;
            ptr_r <= ptr_nxt;
            fw_r <= fw_nxt;
            done_r <= done_nxt;
        end
    end

    // Decoder must hold off while busy; a new request then is ignored
    assign busy_out = (state_r == CAS_ST_STALL);
    assign done_out = done_r;
    assign fwrite_out = fw_r;
    assign acc_out = acc_r;
    assign flags_out = flags_r;
    assign ptr0_out = ptr_r[0];
    assign ptr1_out = ptr_r[1];

endmodule : cas_datapath
`default_nettype wire

// *** testbench/cas_datapath_sva.sv ***
`timescale 1ns/1ns
`default_nettype none
module cas_datapath_sva
    import cas_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic instr_valid_in,
    input var cas_instr_t instr_in,
    input wire logic indirect_in,
    input wire logic [7:0] file_rdata_in,
    input wire logic busy_out,
    input wire logic done_out,
    input var cas_fwrite_t fwrite_out,
    input wire logic [7:0] acc_out,
    input var cas_flags_t flags_out,
    input wire logic [15:0] ptr0_out,
    input wire logic [15:0] ptr1_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);
    // Stalled ops read file data a cycle late, so data checks skip them
    wire logic go = instr_valid_in && !busy_out;
    wire logic slow = indirect_in && (instr_in.ptr_sel ? ptr1_out[15] : ptr0_out[15]);
    wire logic run = go && !slow;
    property p_fast; run |=> done_out && !busy_out; endproperty
    a_fast: assert property (p_fast) else $error("done late");
    property p_slow; go && slow |=> busy_out && !done_out ##1 done_out && !busy_out; endproperty
    a_slow: assert property (p_slow) else $error("stall wrong");
    property p_andl; run && instr_in.op == CAS_OP_AND_LITERAL_INTO_ACC |=> acc_out == ($past(acc_out)
        & $past(instr_in.literal)) && flags_out.zero == (acc_out == 8'h00) && $stable(flags_out[2:1]); endproperty
    a_andl: assert property (p_andl) else $error("and literal wrong");
    property p_addl; run && instr_in.op == CAS_OP_ADD_LITERAL_INTO_ACC |=>
        {flags_out.carry, acc_out} == {1'h0, $past(acc_out)} + {1'h0, $past(instr_in.literal)}; endproperty
    a_addl: assert property (p_addl) else $error("add literal wrong");
    property p_ptr; run && instr_in.op == CAS_OP_ADD_LITERAL_TO_POINTER && !instr_in.ptr_sel |=> $stable(flags_out)
        && ptr0_out == $past(ptr0_out) + {{10{$past(instr_in.literal[5])}}, $past(instr_in.literal[5:0])}; endproperty
    a_ptr: assert property (p_ptr) else $error("pointer add wrong");
    property p_asr; run && instr_in.op == CAS_OP_SHIFT_RIGHT_ARITH && instr_in.dest_file |=> fwrite_out.en &&
        fwrite_out.data == {$past(file_rdata_in[7]), $past(file_rdata_in[7:1])} && flags_out.carry == $past(file_rdata_in[0]);
    endproperty
    a_asr: assert property (p_asr) else $error("shift wrong");
    property p_bcf; run && instr_in.op == CAS_OP_BIT_CLEAR_FILE |=> $stable(flags_out) &&
        fwrite_out.data == ($past(file_rdata_in) & ~(8'h01 << $past(instr_in.bit_idx))); endproperty
    a_bcf: assert property (p_bcf) else $error("bit clear wrong");
    property p_dst; run && instr_in.op == CAS_OP_AND_ACC_WITH_FILE && !instr_in.dest_file |=> !fwrite_out.en &&
        acc_out == ($past(acc_out) & $past(file_rdata_in)); endproperty
    a_dst: assert property (p_dst) else $error("file and wrong");
    c_slow: cover property (go && slow);
    c_carry: cover property (run && instr_in.op == CAS_OP_ADD_ACC_FILE_WITH_OVERFLOW);
    c_ptr1: cover property (run && instr_in.op == CAS_OP_ADD_LITERAL_TO_POINTER && instr_in.ptr_sel);
endmodule : cas_datapath_sva
bind cas_datapath cas_datapath_sva u_sva (.ref_clk_in, .rst_b_in, .instr_valid_in, .instr_in, .indirect_in,
    .file_rdata_in, .busy_out, .done_out, .fwrite_out, .acc_out, .flags_out, .ptr0_out, .ptr1_out);
`default_nettype wire

// *** testbench/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb;
    import cas_pkg::*;
    logic ref_clk_in = 1'h0;
    logic rst_b_in = 1'h0;
    logic instr_valid_in = 1'h0;
    cas_instr_t instr_in = '0;
    logic indirect_in = 1'h0;
    logic [7:0] file_rdata_in = 8'h00;
    logic busy_out;
    logic done_out;
    cas_fwrite_t fwrite_out;
    logic [7:0] acc_out;
    cas_flags_t flags_out;
    logic [15:0] ptr0_out;
    logic [15:0] ptr1_out;
    logic [15:0] ep0 = 16'h0000;
    logic [15:0] ep1 = 16'h0000;
    int n_errors = 0;
    int num_checks = 0;
    always #4 ref_clk_in = ~ref_clk_in;
    cas_datapath dut (.ref_clk_in, .rst_b_in, .instr_valid_in, .instr_in, .indirect_in, .file_rdata_in,
        .busy_out, .done_out, .fwrite_out, .acc_out, .flags_out, .ptr0_out, .ptr1_out);
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk
    // Valid stays high between steps so ops run back to back
    task automatic step(input cas_op_t op, input logic [7:0] lit, input logic d, input logic [7:0] rd,
        input logic [7:0] acc, input logic [2:0] fl, input logic [15:0] fw);
        logic st;
        st = indirect_in && (lit[7] ? ep1[15] : ep0[15]);
        instr_in = '{op, lit, lit[6:0], d, lit[2:0], lit[7]};
        file_rdata_in = rd;
        instr_valid_in = 1'h1;
        @(negedge ref_clk_in);
        if (st) begin
            chk("busy", 16'h0001, {15'h0000, busy_out});
            @(negedge ref_clk_in);
        end
        chk("done", 16'h0001, {15'h0000, done_out});
        chk("acc", {8'h00, acc}, {8'h00, acc_out});
        chk("flags", {13'h0000, fl}, {13'h0000, flags_out});
        chk("write", fw, fw[15] ? fwrite_out : {fwrite_out.en, 15'h0000});
        chk("ptr0", ep0, ptr0_out);
        chk("ptr1", ep1, ptr1_out);
    endtask : step
    task automatic t_acc();
        step(CAS_OP_ADD_LITERAL_INTO_ACC, 8'hF8, 1'h0, 8'h00, 8'hF8, 3'h0, 16'h0000);
        step(CAS_OP_ADD_LITERAL_INTO_ACC, 8'h0B, 1'h0, 8'h00, 8'h03, 3'h6, 16'h0000);
        step(CAS_OP_AND_LITERAL_INTO_ACC, 8'h0C, 1'h0, 8'h00, 8'h00, 3'h7, 16'h0000);
        step(CAS_OP_ADD_ACC_FILE_WITH_OVERFLOW, 8'h00, 1'h0, 8'h7F, 8'h80, 3'h2, 16'h0000);
        step(CAS_OP_ADD_ACC_TO_FILE, 8'h12, 1'h1, 8'h85, 8'h80, 3'h4, 16'h9205);
        step(CAS_OP_ADD_ACC_FILE_WITH_OVERFLOW, 8'h44, 1'h1, 8'h70, 8'h80, 3'h0, 16'hC4F1);
        instr_valid_in = 1'h0;
        @(negedge ref_clk_in);
        chk("done idle", 16'h0000, {15'h0000, done_out});
        chk("write idle", 16'h0000, {fwrite_out.en, 15'h0000});
        $display("t_acc done");
    endtask : t_acc
    task automatic t_file();
        step(CAS_OP_SHIFT_RIGHT_ARITH, 8'h7F, 1'h1, 8'h80, 8'h80, 3'h0, 16'hFFC0);
        step(CAS_OP_SHIFT_RIGHT_ARITH, 8'h00, 1'h0, 8'h83, 8'hC1, 3'h4, 16'h0000);
        step(CAS_OP_AND_ACC_WITH_FILE, 8'h33, 1'h1, 8'hF0, 8'hC1, 3'h4, 16'hB3C0);
        step(CAS_OP_AND_ACC_WITH_FILE, 8'h00, 1'h0, 8'h3E, 8'h00, 3'h5, 16'h0000);
        step(CAS_OP_BIT_CLEAR_FILE, 8'h05, 1'h1, 8'hFF, 8'h00, 3'h5, 16'h85DF);
        instr_valid_in = 1'h0;
        @(negedge ref_clk_in);
        chk("done idle", 16'h0000, {15'h0000, done_out});
        chk("write idle", 16'h0000, {fwrite_out.en, 15'h0000});
        $display("t_file done");
    endtask : t_file
    task automatic t_ptr();
        ep0 = 16'hFFE0;
        step(CAS_OP_ADD_LITERAL_TO_POINTER, 8'h20, 1'h0, 8'h00, 8'h00, 3'h5, 16'h0000);
        ep1 = 16'h001F;
        step(CAS_OP_ADD_LITERAL_TO_POINTER, 8'h9F, 1'h0, 8'h00, 8'h00, 3'h5, 16'h0000);
        ep0 = 16'hFFFF;
        step(CAS_OP_ADD_LITERAL_TO_POINTER, 8'h1F, 1'h0, 8'h00, 8'h00, 3'h5, 16'h0000);
        indirect_in = 1'h1;
        step(CAS_OP_AND_LITERAL_INTO_ACC, 8'h3F, 1'h0, 8'h00, 8'h00, 3'h5, 16'h0000);
        step(CAS_OP_AND_LITERAL_INTO_ACC, 8'hBF, 1'h0, 8'h00, 8'h00, 3'h5, 16'h0000);
        indirect_in = 1'h0;
        ep0 = 16'h0000;
        step(CAS_OP_ADD_LITERAL_TO_POINTER, 8'h01, 1'h0, 8'h00, 8'h00, 3'h5, 16'h0000);
        step(CAS_OP_NONE, 8'h00, 1'h0, 8'h00, 8'h00, 3'h5, 16'h0000);
        instr_valid_in = 1'h0;
        @(negedge ref_clk_in);
        chk("done idle", 16'h0000, {15'h0000, done_out});
        $display("t_ptr done");
    endtask : t_ptr
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up
    initial begin
        #20000;
        n_errors++;
        wrap_up();
    end
    initial begin
        repeat (16) @(negedge ref_clk_in);
        rst_b_in = 1'h1;
        t_acc();
        t_file();
        t_ptr();
        wrap_up();
    end
endmodule : tb
`default_nettype wire
